/* File: include/pps_pkg.sv */
// constants and types of the pushbutton power sequencer
package pps_pkg;
   // slow reference tick period and interval lengths
   localparam int unsigned SLOW_TICK_NS = 1_000_000;
   localparam int unsigned CLK_NS = 10;
   localparam int unsigned SLOW_TICK_CYC = SLOW_TICK_NS / CLK_NS;
   localparam int unsigned DEBOUNCE_MS = 32;
   localparam int unsigned INT_MIN_MS = 32;
   localparam int unsigned BLANK_MS = 512;
   localparam int unsigned LOCKOUT_MS = 1000;
   localparam int unsigned HOLD_TICKS = 16;
   localparam int unsigned CNT_W = 10;
   localparam int unsigned HOLD_W = 5;

   // sequencer states
   typedef enum logic [3:0] {
      PPS_INIT_LOCK,
      PPS_OFF_IDLE,
      PPS_ON_DEBOUNCE,
      PPS_BLANK,
      PPS_ON_RUN,
      PPS_OFF_DEBOUNCE,
      PPS_INT_MIN,
      PPS_HOLD_COUNT,
      PPS_INT_WAIT,
      PPS_WAIT_RELEASE,
      PPS_LOCKOUT
   } pps_state_e;

   // synchronised inputs
   typedef struct packed {
      logic button_n;
      logic sense;
      logic release_n;
      logic tick;
   } pps_in_s;
endpackage : pps_pkg

/* File: src/pps_sequencer.sv */
// pushbutton power sequencer state machine
`timescale 1ns/1ps
`default_nettype none

// Contract
// - turn on after 32 ms steady press
// - supply sense rise also turns on
// - blanking holds enable, ignores inputs
// - held button ignored until seen high
// - monitor status follows supply sense
// - debounced press drives request, min width
// - release low clears request, drops enable
// - release low drops enable outside blanking
// - held button counts ticks, then forces off
// - button up during count aborts turn-off
// - lockout after off ignores inputs
// - lockout after a button-requested off waits for button high
// - sense fall turns off only if allowed
// - sense fall drives request at once
// - sense low after ticks forces off
// - button turn-on ignores supply sense
// - sense turn-on accepts both off triggers
// - variant without allow ignores sense fall
// - button has priority over simultaneous sense
// - sense high at power-up turns on
// - build option for enable polarity
// - tied tick never forces off
module pps_sequencer import pps_pkg::*; #(
   parameter int unsigned SLOW_CYC = SLOW_TICK_CYC,
   parameter bit EN_ACTIVE_HIGH = 1'b1,
   parameter bit HAS_OFF_ALLOW = 1'b1
) (
   // clock and reset
   input wire logic I_CLK,
   input wire logic I_RESET,
   // asynchronous pins
   input wire logic I_PUSHBUTTON_N,
   input wire logic I_SUPPLY_SENSE_IN,
   input wire logic I_POWER_RELEASE_N,
   input wire logic I_HOLD_TIMER_TICK,
   input wire logic I_MONITOR_OFF_ALLOW,
   // outputs
   output logic O_POWER_ENABLE,
   output logic O_SHUTDOWN_REQUEST_N_O,
   output logic O_SHUTDOWN_REQUEST_N_OE,
   output logic O_MONITOR_STATUS
);

   pps_in_s meta_q;
   pps_in_s sync_q;
   logic allow_meta_q;
   logic allow_q;
   logic sense_prev_q;
   logic tick_prev_q;
   logic [$clog2(SLOW_CYC+1)-1:0] div_q;
   logic slow_tick;
   logic [CNT_W-1:0] ms_q;
   logic [HOLD_W-1:0] hold_q;
   logic by_sense_q;
   logic seen_high_q;
   logic armed_q;
   logic from_button_q;
   logic en_q;
   logic req_q;
   logic mon_q;
   pps_state_e state_q;
   logic sense_rise;
   logic sense_fall;
   logic ext_tick;
   logic press;
   logic off_allowed;

   // two-stage synchronisers
   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         meta_q <= '{1'b1, 1'b0, 1'b1, 1'b0};
         sync_q <= '{1'b1, 1'b0, 1'b1, 1'b0};
         allow_meta_q <= 1'b0;
         allow_q <= 1'b0;
      end else begin
         meta_q <= '{I_PUSHBUTTON_N, I_SUPPLY_SENSE_IN, I_POWER_RELEASE_N, I_HOLD_TIMER_TICK};
         sync_q <= meta_q;
         allow_meta_q <= I_MONITOR_OFF_ALLOW;
         allow_q <= allow_meta_q;
      end
   end

   // edge history
   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         sense_prev_q <= 1'b0;
         tick_prev_q <= 1'b0;
      end else begin
         sense_prev_q <= sync_q.sense;
         tick_prev_q <= sync_q.tick;
      end
   end

   assign sense_rise = sync_q.sense & ~sense_prev_q;
   assign sense_fall = ~sync_q.sense & sense_prev_q;
   assign ext_tick = sync_q.tick & ~tick_prev_q;
   assign press = ~sync_q.button_n;
   assign off_allowed = HAS_OFF_ALLOW && allow_q && by_sense_q;

   // slow reference divider
   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         div_q <= '0;
      end else if (slow_tick) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 1'b1;
      end
   end
   assign slow_tick = (div_q == ($clog2(SLOW_CYC+1))'(SLOW_CYC - 1));

   // main sequencer
   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         state_q <= PPS_INIT_LOCK;
         ms_q <= '0;
         hold_q <= '0;
         by_sense_q <= 1'b0;
         seen_high_q <= 1'b1;
         armed_q <= 1'b0;
         from_button_q <= 1'b0;
         en_q <= 1'b0;
         req_q <= 1'b0;
      end else begin
         case (state_q)
            PPS_INIT_LOCK: begin
               if (slow_tick) begin
                  ms_q <= ms_q + 1'b1;
               end
               if (slow_tick && ms_q == CNT_W'(LOCKOUT_MS - 1)) begin
                  ms_q <= '0;
                  armed_q <= sync_q.sense;
                  state_q <= PPS_OFF_IDLE;
               end
            end
            PPS_OFF_IDLE: begin
               if (press) begin
                  ms_q <= '0;
                  by_sense_q <= 1'b0;
                  state_q <= PPS_ON_DEBOUNCE;
               end else if (sense_rise || armed_q) begin
                  ms_q <= '0;
                  by_sense_q <= 1'b1;
                  state_q <= PPS_ON_DEBOUNCE;
               end
               armed_q <= 1'b0;
            end
            PPS_ON_DEBOUNCE: begin
               if (!by_sense_q && !press) begin
                  ms_q <= '0;
                  by_sense_q <= sync_q.sense;
                  state_q <= sync_q.sense ? PPS_ON_DEBOUNCE : PPS_OFF_IDLE;
               end else begin
                  if (slow_tick) begin
                     ms_q <= ms_q + 1'b1;
                  end
                  if (slow_tick && ms_q == CNT_W'(DEBOUNCE_MS - 1)) begin
                     ms_q <= '0;
                     en_q <= 1'b1;
                     state_q <= PPS_BLANK;
                  end
               end
            end
            PPS_BLANK: begin
               if (slow_tick) begin
                  ms_q <= ms_q + 1'b1;
               end
               if (slow_tick && ms_q == CNT_W'(BLANK_MS - 1)) begin
                  ms_q <= '0;
                  seen_high_q <= sync_q.button_n;
                  if (!sync_q.release_n) begin
                     en_q <= 1'b0;
                     from_button_q <= 1'b0;
                     state_q <= PPS_WAIT_RELEASE;
                  end else begin
                     state_q <= PPS_ON_RUN;
                  end
               end
            end
            PPS_ON_RUN: begin
               if (sync_q.button_n) begin
                  seen_high_q <= 1'b1;
               end
               if (!sync_q.release_n) begin
                  en_q <= 1'b0;
                  from_button_q <= 1'b0;
                  state_q <= PPS_WAIT_RELEASE;
               end else if (press && seen_high_q) begin
                  ms_q <= '0;
                  state_q <= PPS_OFF_DEBOUNCE;
               end else if (sense_fall && off_allowed) begin
                  req_q <= 1'b1;
                  ms_q <= '0;
                  from_button_q <= 1'b0;
                  state_q <= PPS_INT_MIN;
               end
            end
            PPS_OFF_DEBOUNCE: begin
               if (!sync_q.release_n) begin
                  en_q <= 1'b0;
                  from_button_q <= 1'b0;
                  state_q <= PPS_WAIT_RELEASE;
               end else if (!press) begin
                  state_q <= PPS_ON_RUN;
               end else begin
                  if (slow_tick) begin
                     ms_q <= ms_q + 1'b1;
                  end
                  if (slow_tick && ms_q == CNT_W'(DEBOUNCE_MS - 1)) begin
                     ms_q <= '0;
                     req_q <= 1'b1;
                     by_sense_q <= 1'b0;
                     from_button_q <= 1'b1;
                     state_q <= PPS_INT_MIN;
                  end
               end
            end
            PPS_INT_MIN: begin
               if (slow_tick) begin
                  ms_q <= ms_q + 1'b1;
               end
               if (!sync_q.release_n) begin
                  req_q <= 1'b0;
                  en_q <= 1'b0;
                  state_q <= PPS_WAIT_RELEASE;
               end else if (slow_tick && ms_q == CNT_W'(INT_MIN_MS - 1)) begin
                  ms_q <= '0;
                  hold_q <= '0;
                  if (from_button_q ? press : !sync_q.sense) begin
                     state_q <= PPS_HOLD_COUNT;
                  end else begin
                     state_q <= PPS_INT_WAIT;
                  end
               end
            end
            PPS_HOLD_COUNT: begin
               if (!sync_q.release_n) begin
                  req_q <= 1'b0;
                  en_q <= 1'b0;
                  state_q <= PPS_WAIT_RELEASE;
               end else if (from_button_q && !press) begin
                  req_q <= 1'b0;
                  state_q <= PPS_ON_RUN;
               end else if (ext_tick) begin
                  hold_q <= hold_q + 1'b1;
                  if (hold_q == HOLD_W'(HOLD_TICKS - 1)) begin
                     if (from_button_q || !sync_q.sense) begin
                        req_q <= 1'b0;
                        en_q <= 1'b0;
                        state_q <= PPS_WAIT_RELEASE;
                     end else begin
                        // supply came back, so the host finishes the shutdown
                        state_q <= PPS_INT_WAIT;
                     end
                  end
               end
            end
            PPS_INT_WAIT: begin
               if (!sync_q.release_n) begin
                  req_q <= 1'b0;
                  en_q <= 1'b0;
                  state_q <= PPS_WAIT_RELEASE;
               end
            end
            PPS_WAIT_RELEASE: begin
               if (!from_button_q || sync_q.button_n) begin
                  ms_q <= '0;
                  state_q <= PPS_LOCKOUT;
               end
            end
            PPS_LOCKOUT: begin
               if (slow_tick) begin
                  ms_q <= ms_q + 1'b1;
               end
               if (slow_tick && ms_q == CNT_W'(LOCKOUT_MS - 1)) begin
                  ms_q <= '0;
                  state_q <= PPS_OFF_IDLE;
               end
            end
            default: begin
               state_q <= PPS_INIT_LOCK;
            end
         endcase
      end
   end

   // monitor status register
   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         mon_q <= 1'b0;
      end else begin
         mon_q <= sync_q.sense;
      end
   end

   // output drive
   assign O_POWER_ENABLE = EN_ACTIVE_HIGH ? en_q : ~en_q;
   assign O_SHUTDOWN_REQUEST_N_O = 1'b0;
   assign O_SHUTDOWN_REQUEST_N_OE = req_q;
   assign O_MONITOR_STATUS = mon_q;

   // checks
   enable_blank_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
      $rose(en_q) |-> en_q [*8])
      else $error("enable dropped early in blanking");
   release_off_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
      (state_q == PPS_ON_RUN && !sync_q.release_n) |=> !en_q)
      else $error("release low did not drop enable");
   release_req_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
      (state_q == PPS_INT_WAIT && !sync_q.release_n) |=> !req_q && !en_q)
      else $error("release did not end request");
   abort_hold_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
      (state_q == PPS_HOLD_COUNT && from_button_q && sync_q.release_n && !press) |=> !req_q && en_q)
      else $error("abort did not restore request");
   monitor_follow_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
      mon_q == $past(sync_q.sense))
      else $error("monitor status lags");
   sense_req_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
      (state_q == PPS_ON_RUN && sync_q.release_n && !(press && seen_high_q) && sense_fall && off_allowed)
      |=> req_q)
      else $error("sense fall did not request");
   lockout_hold_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
      (state_q == PPS_LOCKOUT) |=> !en_q)
      else $error("enable asserted in lockout");
   wait_button_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
      (state_q == PPS_WAIT_RELEASE && from_button_q && !sync_q.button_n) |=> state_q == PPS_WAIT_RELEASE)
      else $error("lockout began with button held");
   req_min_a: assert property (@(posedge I_CLK) disable iff (I_RESET)
      ($rose(req_q) && sync_q.release_n) |=> req_q || !sync_q.release_n)
      else $error("request too short");
   cover_on_c: cover property (@(posedge I_CLK) $rose(en_q));
   cover_hold_c: cover property (@(posedge I_CLK) state_q == PPS_HOLD_COUNT);
   cover_sense_c: cover property (@(posedge I_CLK) sense_fall && off_allowed && state_q == PPS_ON_RUN);

endmodule : pps_sequencer

`default_nettype wire

/* File: verification/pps_host.sv */
// host model that boots and answers shutdown requests
`timescale 1ns/1ps
`default_nettype none
module pps_host (
   // clock
   input wire logic clk,
   // behaviour chosen by the bench
   input wire logic boot_ok,
   input wire logic answer,
   input wire logic [15:0] answer_cyc,
   // device pins
   input wire logic enable,
   input wire logic req_oe,
   output logic release_n
);
   logic rel_q = 1'b0;
   logic [15:0] up_q = 16'h0000;
   logic [15:0] wait_q = 16'h0000;
   assign release_n = rel_q;
   // unpowered host holds release low; a booted host lets it go high
   always_ff @(posedge clk) begin
      up_q <= enable ? up_q + 16'h0001 : 16'h0000;
      wait_q <= req_oe ? wait_q + 16'h0001 : 16'h0000;
      if (!enable) begin
         rel_q <= 1'b0;
      end else if (up_q == 16'h00C8 && boot_ok) begin
         rel_q <= 1'b1;
      end else if (req_oe && answer && wait_q == answer_cyc) begin
         rel_q <= 1'b0;
      end
   end
endmodule : pps_host
`default_nettype wire

/* File: verification/testbench.sv */
// self-checking bench of the pushbutton power sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import pps_pkg::*;
   localparam int unsigned SC = 4;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic button_n = 1'b1;
   logic sense = 1'b0;
   logic tick = 1'b0;
   logic allow = 1'b1;
   logic boot_ok = 1'b1;
   logic answer = 1'b1;
   logic en;
   logic req_oe;
   logic mon;
   logic rel_n;
   logic req_o;
   logic en_lo;
   logic req_lo;
   int failures = 0;
   int n_checks = 0;
   int cycles = 0;
   int held;

   // clock and hang limit
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         failures++;
         print_verdict();
      end
   end

   // short slow tick keeps intervals in reach
   pps_sequencer #(.SLOW_CYC(SC)) DUT (.I_CLK(clk), .I_RESET(rst), .I_PUSHBUTTON_N(button_n),
      .I_SUPPLY_SENSE_IN(sense), .I_POWER_RELEASE_N(rel_n), .I_HOLD_TIMER_TICK(tick),
      .I_MONITOR_OFF_ALLOW(allow), .O_POWER_ENABLE(en), .O_SHUTDOWN_REQUEST_N_O(req_o),
      .O_SHUTDOWN_REQUEST_N_OE(req_oe), .O_MONITOR_STATUS(mon));
   // active-low enable variant without the allow input, on the same pins
   pps_sequencer #(.SLOW_CYC(SC), .EN_ACTIVE_HIGH(1'b0), .HAS_OFF_ALLOW(1'b0)) DUT_LOW (.I_CLK(clk),
      .I_RESET(rst), .I_PUSHBUTTON_N(button_n), .I_SUPPLY_SENSE_IN(sense), .I_POWER_RELEASE_N(rel_n),
      .I_HOLD_TIMER_TICK(tick), .I_MONITOR_OFF_ALLOW(allow), .O_POWER_ENABLE(en_lo),
      .O_SHUTDOWN_REQUEST_N_O(), .O_SHUTDOWN_REQUEST_N_OE(req_lo), .O_MONITOR_STATUS());
   // host answers 40 ms into a request
   pps_host HOST (.clk(clk), .boot_ok(boot_ok), .answer(answer), .answer_cyc(16'h00A0),
      .enable(en), .req_oe(req_oe), .release_n(rel_n));

   // expected enable and request pins
   function automatic logic [1:0] pins(input logic on, input logic req);
      return {on, req};
   endfunction : pins

   // a press turns on only when it outlasts the debounce
   function automatic logic on_after(input int ms_held);
      return (ms_held > DEBOUNCE_MS) ? 1'b1 : 1'b0;
   endfunction : on_after

   // compare and count
   task automatic check(input logic [1:0] seen, input logic [1:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // waits, ending just after an edge
   task automatic cy(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cy

   task automatic ms(input int n);
      cy(n * SC);
   endtask : ms

   // external tick pulses
   task automatic ticks(input int n);
      repeat (n) begin
         tick = 1'b1;
         cy(4);
         tick = 1'b0;
         cy(4);
      end
   endtask : ticks

   // verdict and end of run
   task automatic print_verdict();
      if (failures == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : print_verdict

   // scenarios
   initial begin
      void'($urandom(52135));
      cy(10);
      rst = 1'b0;
      // press inside the power-up lockout
      ms(500);
      button_n = 1'b0;
      ms(40);
      button_n = 1'b1;
      ms(2);
      check(pins(en, req_oe), pins(0, 0));
      ms(500);
      // short presses, random and at the edge
      for (int i = 0; i < 2; i++) begin
         held = (i == 0) ? 1 + int'($urandom % 29) : 30;
         button_n = 1'b0;
         ms(held);
         button_n = 1'b1;
         ms(40);
         check({1'b0, en}, {1'b0, on_after(held)});
      end
      // button turn-on held through blanking, then host shutdown
      button_n = 1'b0;
      ms(30);
      check(pins(en, req_oe), pins(0, 0));
      check(pins(en_lo, req_lo), pins(1, 0));
      ms(4);
      check(pins(en, req_oe), pins(1, 0));
      check(pins(en_lo, req_lo), pins(0, 0));
      ms(600);
      check(pins(en, req_oe), pins(1, 0));
      button_n = 1'b1;
      ms(2);
      button_n = 1'b0;
      ms(34);
      check(pins(en, req_oe), pins(1, 1));
      check({1'b0, req_o}, 2'h0);
      button_n = 1'b1;
      ms(20);
      check(pins(en, req_oe), pins(1, 1));
      ms(30);
      check(pins(en, req_oe), pins(0, 0));
      button_n = 1'b0;
      ms(40);
      button_n = 1'b1;
      ms(2);
      check(pins(en, req_oe), pins(0, 0));
      ms(1000);
      // supply turn-on, then supply fall forced off by ticks
      sense = 1'b1;
      ms(34);
      check(pins(en, mon), pins(1, 1));
      ms(520);
      answer = 1'b0;
      sense = 1'b0;
      ms(1);
      check(pins(en, req_oe), pins(1, 1));
      check(pins(~en_lo, req_lo), pins(1, 0));
      ms(34);
      ticks(15);
      check(pins(en, req_oe), pins(1, 1));
      ticks(1);
      cy(8);
      check(pins(en, req_oe), pins(0, 0));
      check({1'b0, mon}, 2'h0);
      check(pins(~en_lo, req_lo), pins(0, 0));
      ms(1010);
      // button turn-on ignores supply, abort and forced turn-off
      button_n = 1'b0;
      ms(34);
      button_n = 1'b1;
      ms(520);
      sense = 1'b1;
      ms(2);
      sense = 1'b0;
      ms(2);
      check(pins(en, req_oe), pins(1, 0));
      button_n = 1'b0;
      ms(68);
      check(pins(en, req_oe), pins(1, 1));
      ticks(8);
      button_n = 1'b1;
      cy(8);
      check(pins(en, req_oe), pins(1, 0));
      button_n = 1'b0;
      ms(68);
      ticks(16);
      cy(8);
      check(pins(en, req_oe), pins(0, 0));
      ms(1100);
      button_n = 1'b1;
      ms(2);
      button_n = 1'b0;
      ms(40);
      button_n = 1'b1;
      ms(2);
      check(pins(en, req_oe), pins(0, 0));
      ms(1000);
      // host never boots, so blanking end drops enable
      boot_ok = 1'b0;
      button_n = 1'b0;
      ms(34);
      button_n = 1'b1;
      ms(470);
      check(pins(en, req_oe), pins(1, 0));
      ms(50);
      check(pins(en, req_oe), pins(0, 0));
      // mid-run reset with supply present, sense fall not allowed
      boot_ok = 1'b1;
      allow = 1'b0;
      sense = 1'b1;
      rst = 1'b1;
      cy(10);
      rst = 1'b0;
      ms(1040);
      check(pins(en, mon), pins(1, 1));
      check(pins(en_lo, req_lo), pins(0, 0));
      ms(560);
      sense = 1'b0;
      ms(4);
      check(pins(en, req_oe), pins(1, 0));
      check(pins(~en_lo, req_lo), pins(1, 0));
      // held button with no hold ticks never forces off
      button_n = 1'b0;
      ms(68);
      check(pins(en, req_oe), pins(1, 1));
      ms(50);
      check(pins(en, req_oe), pins(1, 1));
      check(pins(~en_lo, req_lo), pins(1, 1));
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
